//--- common/gpc_pkg.sv
// Constants, register map and carrier types for the pin configuration block
package gpc_pkg;
    // ------------------------------------------------------------------
    // Register map (word index; byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int GPC_PINS = 10;
    localparam int GPC_ADDR_W = 12;
    localparam int GPC_IDX_W = 10;
    localparam logic [9:0] GPC_IDX_PIN_1_1 = 10'h024;
    localparam logic [9:0] GPC_IDX_PIN_1_2 = 10'h025;
    localparam logic [9:0] GPC_IDX_PIN_1_3 = 10'h026;
    localparam logic [9:0] GPC_IDX_PIN_1_4 = 10'h027;
    localparam logic [9:0] GPC_IDX_PIN_1_5 = 10'h028;
    localparam logic [9:0] GPC_IDX_PIN_1_6 = 10'h029;
    localparam logic [9:0] GPC_IDX_PIN_1_7 = 10'h02A;
    localparam logic [9:0] GPC_IDX_PIN_2_0 = 10'h02B;
    localparam logic [9:0] GPC_IDX_PIN_2_1 = 10'h02C;
    localparam logic [9:0] GPC_IDX_PIN_2_2 = 10'h02D;
    localparam logic [9:0] GPC_IDX_RSVD = 10'h02E;
    localparam logic [9:0] GPC_IDX_OUT_DATA = 10'h040;
    localparam logic [9:0] GPC_IDX_IN_LEVEL = 10'h041;
    localparam logic [9:0] GPC_IDX_IRQ_STATUS = 10'h042;
    localparam logic [9:0] GPC_IDX_IRQ_MASK = 10'h043;
    // First pin with the two-bit function field
    localparam int GPC_WIDE_FIRST = 8;
    // ------------------------------------------------------------------
    // Field layout of a pin configuration register
    // ------------------------------------------------------------------
    localparam int GPC_BIT_DIR = 0;
    localparam int GPC_BIT_POL = 1;
    localparam int GPC_BIT_ALT = 2;
    localparam int GPC_FN_LO = 2;
    localparam int GPC_FN_HI = 3;
    localparam int GPC_BIT_OD = 7;
    localparam logic [7:0] GPC_CFG_RESET = 8'h01;
    localparam logic [7:0] GPC_MASK_NARROW = 8'h87;
    localparam logic [7:0] GPC_MASK_WIDE = 8'h8F;
    localparam logic [1:0] GPC_FN_GPIO = 2'h0;
    localparam logic [1:0] GPC_FN_KBC = 2'h1;
    localparam logic [1:0] GPC_FN_EDGE = 2'h2;
    localparam logic [1:0] GPC_FN_FLOPPY = 2'h3;
    localparam logic [1:0] GPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] GPC_RESP_SLVERR = 2'h2;
    localparam logic [31:0] GPC_ZERO_WORD = 32'h0000_0000;
    localparam logic [9:0] GPC_OUT_RESET = 10'h000;
    localparam logic [1:0] GPC_IRQ_RESET = 2'h0;
    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    // Pin levels handed to the functional units; idle high when not routed
    typedef struct packed {
        logic stick1_button2;
        logic stick2_button1;
        logic stick2_button2;
        logic stick1_x_axis;
        logic stick1_y_axis;
        logic stick2_x_axis;
        logic stick2_y_axis;
        logic kbc_port1_bit7;
        logic kbc_port1_bit6;
        logic kbc_port1_bit2;
    } gpc_alt_level_type;
    // Values the functional units want driven onto their pins
    typedef struct packed {
        logic [6:0] stick_drive;
        logic kbc_port1_bit7;
        logic kbc_port1_bit6;
        logic kbc_port1_bit2;
        logic floppy_drive_sel1_n;
        logic floppy_motor_sel1_n;
    } gpc_alt_drive_type;
endpackage

//--- hw/gpc_pin_cell.sv
// One pad cell: direction, polarity and driver type for a single pin
`timescale 1ns/10ps
module gpc_pin_cell (
    input wire logic [7:0] cfg,
    input wire logic alt_sel,
    input wire logic gpio_data,
    input wire logic alt_data,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic in_level
);
    wire logic dir_in;
    wire logic pol;
    wire logic open_drain;
    wire logic drive_val;

    assign dir_in = cfg[gpc_pkg::GPC_BIT_DIR];
    assign pol = cfg[gpc_pkg::GPC_BIT_POL];
    assign open_drain = cfg[gpc_pkg::GPC_BIT_OD];
    // Inversion acts on both the drive path and the sampled level
    assign drive_val = (alt_sel ? alt_data : gpio_data) ^ pol;
    assign in_level = pad_in ^ pol;
    // Open drain only ever pulls low; a high level is left to the pull-up
    assign pad_out = open_drain ? 1'b0 : drive_val;
    assign pad_oe = !dir_in && (!open_drain || !drive_val);
endmodule

//--- hw/gpc_pin_config.sv
// Pin configuration registers, pad routing and edge interrupts behind AXI4-Lite
`timescale 1ns/10ps
module gpc_pin_config (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] pad_in,
    output logic [9:0] pad_out,
    output logic [9:0] pad_oe,
    input wire gpc_pkg::gpc_alt_drive_type alt_drive,
    output gpc_pkg::gpc_alt_level_type alt_level,
    output logic irq
);
    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] cfg_mask(input int pin);
        cfg_mask = (pin >= gpc_pkg::GPC_WIDE_FIRST) ? gpc_pkg::GPC_MASK_WIDE
                                                    : gpc_pkg::GPC_MASK_NARROW;
    endfunction

    function automatic logic slot_ok(input logic [9:0] idx);
        slot_ok = (idx >= gpc_pkg::GPC_IDX_PIN_1_1 && idx <= gpc_pkg::GPC_IDX_RSVD) ||
                  (idx >= gpc_pkg::GPC_IDX_OUT_DATA && idx <= gpc_pkg::GPC_IDX_IRQ_MASK);
    endfunction

    function automatic logic [31:0] read_word(
        input logic [9:0] idx,
        input logic [79:0] cfg_flat,
        input logic [9:0] out_v,
        input logic [9:0] lvl_v,
        input logic [1:0] stat_v,
        input logic [1:0] mask_v
    );
        logic [9:0] off;
        off = idx - gpc_pkg::GPC_IDX_PIN_1_1;
        read_word = gpc_pkg::GPC_ZERO_WORD;
        if (idx >= gpc_pkg::GPC_IDX_PIN_1_1 && idx <= gpc_pkg::GPC_IDX_PIN_2_2) begin
            read_word = {24'h000000, cfg_flat[off[3:0] * 8 +: 8]};
        end else if (idx == gpc_pkg::GPC_IDX_OUT_DATA) begin
            read_word = {22'h000000, out_v};
        end else if (idx == gpc_pkg::GPC_IDX_IN_LEVEL) begin
            read_word = {22'h000000, lvl_v};
        end else if (idx == gpc_pkg::GPC_IDX_IRQ_STATUS) begin
            read_word = {30'h00000000, stat_v};
        end else if (idx == gpc_pkg::GPC_IDX_IRQ_MASK) begin
            read_word = {30'h00000000, mask_v};
        end
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0] cfg [gpc_pkg::GPC_PINS];
    logic [79:0] cfg_flat;
    logic [9:0] out_data;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [1:0] lvl_prev;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    wire logic [9:0] in_level;
    wire logic [9:0] alt_sel;
    wire logic [9:0] alt_data;
    wire logic [9:0] dir_bits;
    wire logic [9:0] pol_bits;
    wire logic [9:0] od_bits;
    wire logic [1:0] fn_2_1;
    wire logic [1:0] fn_2_2;

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    wire logic wr_en;
    wire logic [9:0] wr_idx;
    wire logic [9:0] wr_off;
    wire logic [9:0] wr_bits;
    wire logic [9:0] wr_lane;
    wire logic [1:0] w1c;

    // Address and data may arrive in either order; each is held until both are in
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_en = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx = aw_addr[11:2];
    assign wr_off = wr_idx - gpc_pkg::GPC_IDX_PIN_1_1;
    assign wr_lane = {{2{w_strb[1]}}, {8{w_strb[0]}}};
    assign wr_bits = w_data[9:0];
    assign w1c = (wr_en && wr_idx == gpc_pkg::GPC_IDX_IRQ_STATUS && w_strb[0])
                 ? w_data[1:0] : 2'h0;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= gpc_pkg::GPC_ZERO_WORD;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_en) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_en) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpc_pkg::GPC_RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= slot_ok(wr_idx) ? gpc_pkg::GPC_RESP_OKAY
                                           : gpc_pkg::GPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers and pad cells
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < gpc_pkg::GPC_PINS; gi++) begin : g_pin
            wire logic hit;
            assign hit = wr_en && w_strb[0] && wr_idx <= gpc_pkg::GPC_IDX_PIN_2_2 &&
                         wr_off == 10'(gi);
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    cfg[gi] <= gpc_pkg::GPC_CFG_RESET;
                end else if (hit) begin
                    cfg[gi] <= w_data[7:0] & cfg_mask(gi);
                end
            end
            assign cfg_flat[gi * 8 +: 8] = cfg[gi];
            assign dir_bits[gi] = cfg[gi][gpc_pkg::GPC_BIT_DIR];
            assign pol_bits[gi] = cfg[gi][gpc_pkg::GPC_BIT_POL];
            assign od_bits[gi] = cfg[gi][gpc_pkg::GPC_BIT_OD];
            gpc_pin_cell u_cell (
                .cfg(cfg[gi]),
                .alt_sel(alt_sel[gi]),
                .gpio_data(out_data[gi]),
                .alt_data(alt_data[gi]),
                .pad_in(pad_in[gi]),
                .pad_out(pad_out[gi]),
                .pad_oe(pad_oe[gi]),
                .in_level(in_level[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Alternate function routing
    // ------------------------------------------------------------------
    assign fn_2_1 = cfg[8][gpc_pkg::GPC_FN_HI:gpc_pkg::GPC_FN_LO];
    assign fn_2_2 = cfg[9][gpc_pkg::GPC_FN_HI:gpc_pkg::GPC_FN_LO];
    // Edge mode keeps the GPIO drive path; only the sampled level is used
    assign alt_sel[7:0] = {cfg[7][gpc_pkg::GPC_BIT_ALT], cfg[6][gpc_pkg::GPC_BIT_ALT],
                           cfg[5][gpc_pkg::GPC_BIT_ALT], cfg[4][gpc_pkg::GPC_BIT_ALT],
                           cfg[3][gpc_pkg::GPC_BIT_ALT], cfg[2][gpc_pkg::GPC_BIT_ALT],
                           cfg[1][gpc_pkg::GPC_BIT_ALT], cfg[0][gpc_pkg::GPC_BIT_ALT]};
    assign alt_sel[8] = fn_2_1 == gpc_pkg::GPC_FN_KBC || fn_2_1 == gpc_pkg::GPC_FN_FLOPPY;
    assign alt_sel[9] = fn_2_2 == gpc_pkg::GPC_FN_KBC || fn_2_2 == gpc_pkg::GPC_FN_FLOPPY;
    assign alt_data[6:0] = alt_drive.stick_drive;
    assign alt_data[7] = alt_drive.kbc_port1_bit7;
    assign alt_data[8] = (fn_2_1 == gpc_pkg::GPC_FN_FLOPPY) ? alt_drive.floppy_drive_sel1_n
                                                            : alt_drive.kbc_port1_bit6;
    assign alt_data[9] = (fn_2_2 == gpc_pkg::GPC_FN_FLOPPY) ? alt_drive.floppy_motor_sel1_n
                                                            : alt_drive.kbc_port1_bit2;

    // Levels to the units are registered; an unrouted pin reads idle high
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            alt_level <= '1;
        end else begin
            alt_level.stick1_button2 <= !alt_sel[0] || in_level[0];
            alt_level.stick2_button1 <= !alt_sel[1] || in_level[1];
            alt_level.stick2_button2 <= !alt_sel[2] || in_level[2];
            alt_level.stick1_x_axis <= !alt_sel[3] || in_level[3];
            alt_level.stick1_y_axis <= !alt_sel[4] || in_level[4];
            alt_level.stick2_x_axis <= !alt_sel[5] || in_level[5];
            alt_level.stick2_y_axis <= !alt_sel[6] || in_level[6];
            alt_level.kbc_port1_bit7 <= !alt_sel[7] || in_level[7];
            alt_level.kbc_port1_bit6 <= fn_2_1 != gpc_pkg::GPC_FN_KBC || in_level[8];
            alt_level.kbc_port1_bit2 <= fn_2_2 != gpc_pkg::GPC_FN_KBC || in_level[9];
        end
    end

    // ------------------------------------------------------------------
    // Output data, edge interrupts, status and mask
    // ------------------------------------------------------------------
    wire logic [1:0] edge_arm;
    wire logic [1:0] edge_evt;
    wire logic [1:0] next_status;

    assign edge_arm = {fn_2_2 == gpc_pkg::GPC_FN_EDGE, fn_2_1 == gpc_pkg::GPC_FN_EDGE};
    // Either edge counts, so a plain change of level is the event
    assign edge_evt = edge_arm & (in_level[9:8] ^ lvl_prev);
    // A new edge in the clearing cycle survives the clear
    assign next_status = (irq_status & ~w1c) | edge_evt;
    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lvl_prev <= 2'h0;
            irq_status <= gpc_pkg::GPC_IRQ_RESET;
        end else begin
            lvl_prev <= in_level[9:8];
            irq_status <= next_status;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_data <= gpc_pkg::GPC_OUT_RESET;
            irq_mask <= gpc_pkg::GPC_IRQ_RESET;
        end else if (wr_en) begin
            if (wr_idx == gpc_pkg::GPC_IDX_OUT_DATA) begin
                out_data <= (out_data & ~wr_lane) | (wr_bits & wr_lane);
            end
            if (wr_idx == gpc_pkg::GPC_IDX_IRQ_MASK && w_strb[0]) begin
                irq_mask <= w_data[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    wire logic [9:0] rd_idx;
    wire logic [31:0] rd_word;

    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx = s_axi_araddr[11:2];
    // The reserved slot falls through to zero inside read_word
    assign rd_word = read_word(rd_idx, cfg_flat, out_data, in_level,
                               irq_status, irq_mask);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= gpc_pkg::GPC_ZERO_WORD;
            s_axi_rresp <= gpc_pkg::GPC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= slot_ok(rd_idx) ? gpc_pkg::GPC_RESP_OKAY
                                           : gpc_pkg::GPC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_dir_input_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (pad_oe & dir_bits) == 10'h000)
        else $error("input pin is being driven");

    chk_polarity_level: assert property (@(posedge ref_clk) disable iff (!arst_n)
        in_level == (pad_in ^ pol_bits))
        else $error("sampled level ignores polarity");

    chk_open_drain_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (pad_oe & pad_out & od_bits) == 10'h000)
        else $error("open drain pin drives high");

    chk_stick_route: assert property (@(posedge ref_clk) disable iff (!arst_n)
        cfg[3][gpc_pkg::GPC_BIT_ALT] |=> alt_level.stick1_x_axis == $past(in_level[3]))
        else $error("joystick axis level not routed");

    chk_kbc7_drive: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (alt_sel[7] && !dir_bits[7] && !od_bits[7]) |->
        (pad_oe[7] && pad_out[7] == (alt_drive.kbc_port1_bit7 ^ pol_bits[7])))
        else $error("keyboard bit 7 not driven on pin");

    chk_kbc6_route: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fn_2_1 == gpc_pkg::GPC_FN_KBC |=> alt_level.kbc_port1_bit6 == $past(in_level[8]))
        else $error("keyboard bit 6 level not routed");

    chk_edge_event: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (edge_arm[1] && in_level[9] != lvl_prev[1]) |=> irq_status[1])
        else $error("pin edge did not set status");

    chk_floppy_sel: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (fn_2_1 == gpc_pkg::GPC_FN_FLOPPY && !dir_bits[8] && !od_bits[8]) |->
        pad_out[8] == (alt_drive.floppy_drive_sel1_n ^ pol_bits[8]))
        else $error("drive select not on pin");

    chk_rsvd_read: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (s_axi_arvalid && s_axi_arready && rd_idx == gpc_pkg::GPC_IDX_RSVD) |=>
        (s_axi_rvalid && s_axi_rdata == gpc_pkg::GPC_ZERO_WORD))
        else $error("reserved slot read not zero");

    chk_rsvd_bits: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ((cfg[0] & ~gpc_pkg::GPC_MASK_NARROW) == 8'h00) &&
        ((cfg[9] & ~gpc_pkg::GPC_MASK_WIDE) == 8'h00))
        else $error("reserved config bit set");
endmodule

//--- verification/tb_gpc_pin_config.sv
// Self-checking bench for the pin configuration block
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_gpc_pin_config;
    logic ref_clk = 1'h0;
    logic arst_n = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_wvalid = 1'h0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'h0;
    logic [9:0] pad_in = 10'h000;
    gpc_pkg::gpc_alt_drive_type alt_drive = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d, rnd;
    logic [9:0] pad_out, pad_oe, od;
    logic [7:0] c;
    logic v;
    gpc_pkg::gpc_alt_level_type alt_level;
    int seed, i, bad_count = 0, n_compared = 0;
    // ------------------------------------------------------------
    // Design, clock and watchdog
    // ------------------------------------------------------------
    gpc_pin_config u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(1'h1), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'h1),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .alt_drive(alt_drive),
        .alt_level(alt_level), .irq(irq));
    always #20 ref_clk = ~ref_clk;
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // Bus tasks and expectation functions
    // ------------------------------------------------------------
    // Each channel is released at the rising edge that takes it; the answer is read there too
    task automatic axw(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] rs);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= wd;
            s_axi_awvalid <= 1'h1;
            s_axi_wvalid <= 1'h1;
            do begin
                @(posedge ref_clk);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            end while (!s_axi_bvalid);
            rs = s_axi_bresp;
        end
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rs);
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            do begin
                @(posedge ref_clk);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            end while (!s_axi_rvalid);
            rd = s_axi_rdata;
            rs = s_axi_rresp;
        end
    endtask
    function automatic logic [11:0] pin_addr(input int p);
        return 12'h090 + 12'(4 * p);
    endfunction
    function automatic logic src_bit(input int p, input logic [7:0] cf, input logic [9:0] o,
        input gpc_pkg::gpc_alt_drive_type ad);
        if (p < 7) return cf[2] ? ad.stick_drive[p] : o[p];
        if (p == 7) return cf[2] ? ad.kbc_port1_bit7 : o[7];
        case (cf[3:2])
            gpc_pkg::GPC_FN_KBC: return (p == 8) ? ad.kbc_port1_bit6 : ad.kbc_port1_bit2;
            gpc_pkg::GPC_FN_FLOPPY:
                return (p == 8) ? ad.floppy_drive_sel1_n : ad.floppy_motor_sel1_n;
            default: return o[p];
        endcase
    endfunction
    function automatic logic routed(input int p, input logic [7:0] cf);
        return (p < 8) ? cf[2] : (cf[3:2] == gpc_pkg::GPC_FN_KBC);
    endfunction
    task automatic tog(input logic [9:0] p, input logic [31:0] st, input logic q);
        begin
            pad_in <= p;
            repeat (3) @(posedge ref_clk);
            axr(12'h108, d, r);
            `CHK(d, st)
            @(negedge ref_clk);
            `CHK(irq, q)
            @(posedge ref_clk);
        end
    endtask
    task automatic wrap_up;
        begin
            $display("compared %0d mismatches %0d", n_compared, bad_count);
            if (bad_count == 0 && n_compared > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        seed = 19674;
        repeat (9) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(pad_oe, 10'h000)
        `CHK(alt_level, 10'h3FF)
        @(posedge ref_clk);
        arst_n <= 1'h1;
        @(posedge ref_clk);
        axw(12'h0B8, 32'hFF, r);
        `CHK(r, gpc_pkg::GPC_RESP_OKAY)
        for (int k = 0; k < 11; k++) begin
            axr(pin_addr(k), d, r);
            `CHK(d, (k == 10) ? 32'h0 : 32'h1)
            `CHK(r, gpc_pkg::GPC_RESP_OKAY)
        end
        axr(12'hFFC, d, r);
        `CHK(r, gpc_pkg::GPC_RESP_SLVERR)
        `CHK(d, 32'h0)
        axw(12'hFFC, 32'h1, r);
        `CHK(r, gpc_pkg::GPC_RESP_SLVERR)
        $display("test reset_and_reserved done");
        // First eight passes sweep every function code on pins 8 and 9, the next eight select the alternate on pins 0 to 7, then random mixes
        for (int k = 0; k < 80; k++) begin
            rnd = $random(seed);
            i = (k < 8) ? 8 + k % 2 : (k < 16) ? k - 8 : int'(rnd[31:28]) % 10;
            c = (k < 8) ? {4'h0, 2'(k / 2), 2'h0} : (k < 16) ? 8'h04 : rnd[7:0];
            od = rnd[17:8];
            axw(pin_addr(i), {24'h0, c}, r);
            axw(12'h100, {22'h0, od}, r);
            rnd = $random(seed);
            alt_drive <= rnd[11:0];
            pad_in <= rnd[21:12];
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            c = c & ((i >= gpc_pkg::GPC_WIDE_FIRST) ? gpc_pkg::GPC_MASK_WIDE
                                                    : gpc_pkg::GPC_MASK_NARROW);
            v = src_bit(i, c, od, alt_drive) ^ c[1];
            `CHK(pad_oe[i], !c[0] && (!c[7] || !v))
            if (!c[0] && !c[7]) `CHK(pad_out[i], v)
            `CHK(alt_level[9 - i], routed(i, c) ? pad_in[i] ^ c[1] : 1'h1)
            @(posedge ref_clk);
            axr(pin_addr(i), d, r);
            `CHK(d, {24'h0, c})
            axr(12'h104, d, r);
            `CHK(d[i], pad_in[i] ^ c[1])
        end
        $display("test pin_routing done");
        axw(pin_addr(8), 32'h9, r);
        axw(pin_addr(9), 32'hB, r);
        pad_in <= 10'h200;
        repeat (3) @(posedge ref_clk);
        axw(12'h10C, 32'h1, r);
        axw(12'h108, 32'h3, r);
        tog(10'h200, 32'h0, 1'h0);
        tog(10'h300, 32'h1, 1'h1);
        axw(12'h108, 32'h1, r);
        tog(10'h200, 32'h1, 1'h1);
        axw(12'h108, 32'h1, r);
        // Pin 2.2 is inverted and masked: its event must not reach irq
        tog(10'h000, 32'h2, 1'h0);
        axw(12'h10C, 32'h3, r);
        @(negedge ref_clk);
        `CHK(irq, 1'h1)
        @(posedge ref_clk);
        axw(12'h108, 32'h3, r);
        tog(10'h000, 32'h0, 1'h0);
        $display("test edge_interrupts done");
        wrap_up();
    end
endmodule
